//--- sdrf_chk.sv
// Checker of the reply framer handshakes and frame layout
module sdrf_chk (
    input wire clock,
    input wire reset,
    input wire req_valid,
    input wire req_ready,
    input wire [15:0] req_transaction_identifier,
    input wire [7:0] req_function_code,
    input wire [15:0] req_selection,
    input wire [15:0] req_length,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [15:0] tid_reg;
    logic [7:0] code_reg;
    logic [8:0] cnt_reg;
    logic busy_reg;
    wire take = req_valid && req_ready;
    wire acc = tx_valid && tx_ready;
    // Keep what was asked, since the host changes its fields once taken
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tid_reg <= 16'h0000;
            code_reg <= 8'h00;
            cnt_reg <= 9'h000;
        end else if (take) begin
            busy_reg <= 1'b1;
            tid_reg <= req_transaction_identifier;
            code_reg <= req_function_code != 8'h47 ? 8'h01 : !(req_selection inside {16'h0001, 16'h0002}) ? 8'h02
                : req_length != 16'h0004 ? 8'h03 : 8'h00;
            cnt_reg <= 9'h000;
        end else if (acc) begin
            cnt_reg <= cnt_reg + 9'h001;
        end
    end
    // Frame in flight from take until its final byte is accepted
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else if (take) begin
            busy_reg <= 1'b1;
        end else if (acc && tx_last) begin
            busy_reg <= 1'b0;
        end
    end
    a_take_answer: assert property (take |=> !req_ready ##1 tx_valid)
        else $error("no header byte two cycles after take");
    a_data_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("byte changed while sink stalled");
    a_busy_block: assert property (tx_valid || busy_reg |-> !req_ready)
        else $error("request accepted during a frame");
    a_idle_after: assert property (acc && tx_last |=> !tx_valid && req_ready)
        else $error("framer not idle after final byte");
    a_tid_echo: assert property (tx_valid && cnt_reg < 9'h002 |-> tx_data == (cnt_reg[0] ? tid_reg[7:0] : tid_reg[15:8]))
        else $error("transaction identifier not echoed");
    a_len_field: assert property (tx_valid && cnt_reg == 9'h005 |-> tx_data == (code_reg == 8'h00 ? 8'hfd : 8'h03))
        else $error("wrong length field");
    a_func_code: assert property (tx_valid && cnt_reg == 9'h007 |-> tx_data == 8'h47)
        else $error("wrong function code byte");
    a_frame_len: assert property (tx_valid && tx_last |-> cnt_reg == (code_reg == 8'h00 ? 9'h102 : 9'h008))
        else $error("final byte at wrong position");
    a_fail_code: assert property (tx_valid && tx_last && code_reg != 8'h00 |-> tx_data == code_reg)
        else $error("wrong failure code");
endmodule // sdrf_chk

bind sdrf_framer sdrf_chk u_sdrf_chk (.clock, .reset, .req_valid, .req_ready, .req_transaction_identifier,
    .req_function_code, .req_selection, .req_length, .tx_valid, .tx_data, .tx_last, .tx_ready);

//--- sdrf_framer.v
// Reply framer for the acquire-data command: header, four sample sets, unit health
// What this block does
// - Payload order: status, then per set date, time, eight values, eight statuses, health.
// - Value four bytes, status one, date ten, time twelve, health two bytes.
// - Normal reply holds exactly four sample sets, each with own stamp.
// - Date is yyyy-mm-dd text, time is hh:mm:ss.nnn text.
// - Good header: protocol zero, length 0x00fd, station one, function 0x47, status.
// - Failure reply: length 0x0003, function 0x47, one failure byte, no samples.
// - Unknown function code gives failure code one.
// - Start register out of range gives failure code two.
// - Register count out of range gives failure code three.
// - Selection one sends newest block, two resends previous; same layout.
// - Acquisition status: zero fine, one buffer not full, two samples lost.
// - Channel status: code in bits 5..0, adjustment flag bit 6, cold junction bit 7.
// - Health word: zero, or fault codes 0x2000, 0x0100, 0x0200, 0x0400 combined.
`include "sdrf_map.vh"

module sdrf_framer (
    input wire clock,
    input wire reset,
    input wire req_valid,
    output wire req_ready,
    input wire [15:0] req_transaction_identifier,
    input wire [7:0] req_function_code,
    input wire [15:0] req_selection,
    input wire [15:0] req_length,
    input wire samp_wr,
    input wire [1:0] samp_set,
    input wire [2:0] samp_ch,
    input wire [31:0] samp_value,
    input wire [5:0] samp_err_code,
    input wire samp_adj_err,
    input wire samp_cj_err,
    input wire stamp_wr,
    input wire [1:0] stamp_set,
    input wire [`SDRF_STAMP_W-1:0] stamp_bcd,
    input wire buf_not_full,
    input wire samples_lost,
    input wire fault_param,
    input wire fault_system,
    input wire fault_memory,
    input wire fault_no_input,
    output wire tx_valid,
    output wire [7:0] tx_data,
    output wire tx_last,
    input wire tx_ready
);

    // Two banks: one fills from acquisition, the other holds the last delivered block
    reg [31:0] value_mem [0:63];
    reg [7:0] sts_mem [0:15 * 4 + 3];
    reg [`SDRF_STAMP_W-1:0] stamp_mem [0:7];

    reg [1:0] state_reg;
    reg [5:0] pos_reg;
    reg [1:0] set_reg;
    reg fill_bank_reg;
    reg send_bank_reg;
    reg [15:0] tid_reg;
    reg [7:0] fail_reg;
    reg [7:0] acq_reg;
    reg [15:0] health_reg;
    reg tx_valid_reg;
    reg [7:0] tx_data_reg;
    reg tx_last_reg;

    reg [1:0] state_next;
    reg [5:0] pos_next;
    reg [1:0] set_next;
    reg [7:0] byte_next;
    reg last_next;
    reg [7:0] fail_code;
    reg [7:0] acq_code;
    reg [15:0] health_code;

    wire take_req;
    wire advance;
    wire [5:0] val_off;
    wire [5:0] sts_off;
    wire [31:0] cur_value;
    wire [7:0] cur_sts;
    wire [`SDRF_STAMP_W-1:0] cur_stamp;
    wire [7:0] stamp_char;
    wire [15:0] reply_len;
    wire [15:0] proto_id;

    // Accept a new request only when the previous frame has fully left
    assign req_ready = (state_reg == `SDRF_ST_IDLE) && !tx_valid_reg;
    assign take_req = req_valid && req_ready;
    assign advance = (state_reg != `SDRF_ST_IDLE) && (!tx_valid_reg || tx_ready);

    assign tx_valid = tx_valid_reg;
    assign tx_data = tx_data_reg;
    assign tx_last = tx_last_reg;

    // Offsets of the current byte inside the value and status fields of a set
    assign val_off = pos_reg - `SDRF_VAL_START;
    assign sts_off = pos_reg - `SDRF_STS_START;
    assign cur_value = value_mem[{send_bank_reg, set_reg, val_off[4:2]}];
    assign cur_sts = sts_mem[{send_bank_reg, set_reg, sts_off[2:0]}];
    assign cur_stamp = stamp_mem[{send_bank_reg, set_reg}];
    assign reply_len = (fail_reg == `SDRF_FAIL_NONE) ? `SDRF_LEN_OK : `SDRF_LEN_ERR;
    // Named word so each header byte is cut from it at the right width
    assign proto_id = `SDRF_PROTO_ID;

    sdrf_stamp_text u_text (
        .stamp(cur_stamp),
        .char_idx(pos_reg[4:0]),
        .char_out(stamp_char)
    );

    // Request checks, first failing check wins
    always @* begin
        if (req_function_code != `SDRF_FC_ACQUIRE) begin
            fail_code = `SDRF_FAIL_FUNC;
        end else if (req_selection != `SDRF_SEL_LATEST && req_selection != `SDRF_SEL_RESEND) begin
            fail_code = `SDRF_FAIL_REG;
        end else if (req_length != `SDRF_REQ_LEN) begin
            fail_code = `SDRF_FAIL_COUNT;
        end else begin
            fail_code = `SDRF_FAIL_NONE;
        end
        // Lost samples outrank a partly filled buffer
        if (samples_lost) begin
            acq_code = `SDRF_ACQ_LOST;
        end else if (buf_not_full) begin
            acq_code = `SDRF_ACQ_NOT_FULL;
        end else begin
            acq_code = `SDRF_ACQ_OK;
        end
        // Simultaneous faults OR their codes so none is hidden
        health_code = `SDRF_HLTH_OK
            | (fault_param ? `SDRF_HLTH_PARAM : `SDRF_HLTH_OK)
            | (fault_system ? `SDRF_HLTH_SYSTEM : `SDRF_HLTH_OK)
            | (fault_memory ? `SDRF_HLTH_MEMORY : `SDRF_HLTH_OK)
            | (fault_no_input ? `SDRF_HLTH_NO_INPUT : `SDRF_HLTH_OK);
    end

    // Sample memories; written into the fill bank, never into the held block
    always @(posedge clock) begin
        if (samp_wr) begin
            value_mem[{fill_bank_reg, samp_set, samp_ch}] <= samp_value;
            sts_mem[{fill_bank_reg, samp_set, samp_ch}] <= {samp_cj_err, samp_adj_err, samp_err_code};
        end
        if (stamp_wr) begin
            stamp_mem[{fill_bank_reg, stamp_set}] <= stamp_bcd;
        end
    end

    // Next byte and next position of the frame walk
    always @* begin
        state_next = state_reg;
        pos_next = pos_reg + 6'h01;
        set_next = set_reg;
        byte_next = 8'h00;
        last_next = 1'b0;
        case (state_reg)
            `SDRF_ST_HDR: begin
                case (pos_reg)
                    6'h00: byte_next = tid_reg[15:8];
                    6'h01: byte_next = tid_reg[7:0];
                    6'h02: byte_next = proto_id[15:8];
                    6'h03: byte_next = proto_id[7:0];
                    6'h04: byte_next = reply_len[15:8];
                    6'h05: byte_next = reply_len[7:0];
                    6'h06: byte_next = `SDRF_STATION_ID;
                    6'h07: byte_next = `SDRF_FC_ACQUIRE;
                    default: byte_next = (fail_reg == `SDRF_FAIL_NONE) ? acq_reg : fail_reg;
                endcase
                if (pos_reg == `SDRF_HDR_LAST) begin
                    pos_next = 6'h00;
                    set_next = 2'h0;
                    if (fail_reg != `SDRF_FAIL_NONE) begin
                        state_next = `SDRF_ST_IDLE;
                        last_next = 1'b1;
                    end else begin
                        state_next = `SDRF_ST_SET;
                    end
                end
            end
            `SDRF_ST_SET: begin
                if (pos_reg < `SDRF_VAL_START) begin
                    byte_next = stamp_char;
                end else if (pos_reg < `SDRF_STS_START) begin
                    // Values go out most significant byte first
                    case (val_off[1:0])
                        2'h0: byte_next = cur_value[31:24];
                        2'h1: byte_next = cur_value[23:16];
                        2'h2: byte_next = cur_value[15:8];
                        default: byte_next = cur_value[7:0];
                    endcase
                end else begin
                    byte_next = cur_sts;
                end
                if (pos_reg == `SDRF_SET_LAST) begin
                    pos_next = 6'h00;
                    if (set_reg == `SDRF_LAST_SET) begin
                        state_next = `SDRF_ST_HLTH;
                    end else begin
                        set_next = set_reg + 2'h1;
                    end
                end
            end
            `SDRF_ST_HLTH: begin
                byte_next = (pos_reg == `SDRF_HLTH_LAST) ? health_reg[7:0] : health_reg[15:8];
                if (pos_reg == `SDRF_HLTH_LAST) begin
                    state_next = `SDRF_ST_IDLE;
                    last_next = 1'b1;
                end
            end
            default: begin
                pos_next = pos_reg;
            end
        endcase
    end

    // Frame control and the registered output byte
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= `SDRF_ST_IDLE;
            pos_reg <= 6'h00;
            set_reg <= 2'h0;
            fill_bank_reg <= 1'b0;
            send_bank_reg <= 1'b1;
            tid_reg <= 16'h0000;
            fail_reg <= `SDRF_FAIL_NONE;
            acq_reg <= `SDRF_ACQ_NOT_FULL;
            health_reg <= `SDRF_HLTH_OK;
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_last_reg <= 1'b0;
        end else begin
            if (take_req) begin
                state_reg <= `SDRF_ST_HDR;
                pos_reg <= 6'h00;
                set_reg <= 2'h0;
                tid_reg <= req_transaction_identifier;
                fail_reg <= fail_code;
                // Newest block: freeze the fill bank for sending and fill the other
                if (fail_code == `SDRF_FAIL_NONE && req_selection == `SDRF_SEL_LATEST) begin
                    send_bank_reg <= fill_bank_reg;
                    fill_bank_reg <= ~fill_bank_reg;
                    acq_reg <= acq_code;
                    health_reg <= health_code;
                end
            end else if (advance) begin
                state_reg <= state_next;
                pos_reg <= pos_next;
                set_reg <= set_next;
            end
            if (advance) begin
                tx_valid_reg <= 1'b1;
                tx_data_reg <= byte_next;
                tx_last_reg <= last_next;
            end else if (tx_ready) begin
                tx_valid_reg <= 1'b0;
                tx_last_reg <= 1'b0;
            end
        end
    end

endmodule // sdrf_framer

//--- sdrf_framer_tb.sv
// Self-checking testbench of the acquire-data reply framer
module sdrf_framer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset, req_valid, req_ready, samp_wr, samp_adj_err, samp_cj_err, stamp_wr, tx_valid, tx_last, tx_ready;
    logic buf_not_full, samples_lost, fault_param, fault_system, fault_memory, fault_no_input;
    logic [15:0] req_transaction_identifier, req_selection, req_length, snap_h;
    logic [7:0] req_function_code, tx_data, snap_acq;
    logic [1:0] samp_set, stamp_set;
    logic [2:0] samp_ch;
    logic [31:0] samp_value;
    logic [5:0] samp_err_code;
    logic [67:0] stamp_bcd;
    logic [7:0] exp_b [0:258];
    logic [53:0] rows [0:10];
    int fails = 0;
    int checks = 0;
    int snap_b;
    bit ok;

    sdrf_framer u_sdrf_framer (.clock, .reset, .req_valid, .req_ready, .req_transaction_identifier,
        .req_function_code, .req_selection, .req_length, .samp_wr, .samp_set, .samp_ch, .samp_value,
        .samp_err_code, .samp_adj_err, .samp_cj_err, .stamp_wr, .stamp_set, .stamp_bcd, .buf_not_full,
        .samples_lost, .fault_param, .fault_system, .fault_memory, .fault_no_input, .tx_valid, .tx_data,
        .tx_last, .tx_ready);
    sdrf_host u_sdrf_host (.clock, .req_valid, .req_ready, .req_transaction_identifier, .req_function_code,
        .req_selection, .req_length, .tx_valid, .tx_data, .tx_last, .tx_ready);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Load a whole block into the fill bank: a stamp and eight channels per set
    task automatic fill(int b);
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 8; c++) begin
                @(negedge clock);
                samp_wr = 1'b1;
                stamp_wr = c == 0;
                {samp_set, stamp_set, samp_ch} = {2'(s), 2'(s), 3'(c)};
                samp_value = {8'(b), 8'(s), 8'(c), 8'ha5};
                {samp_cj_err, samp_adj_err, samp_err_code} = {1'(s), 1'(c), 6'(c * 8 + s)};
                stamp_bcd = {16'h2024, 8'h05, 4'h1, 4'(s), 8'h12, 8'h34, 4'h5, 4'(b % 10), 8'h67, 4'(s)};
            end
        end
        @(negedge clock);
        {samp_wr, stamp_wr} = 2'b00;
    endtask

    // One request, then a byte-for-byte compare of the reply
    task automatic run_row(logic [53:0] r, int b);
        logic [15:0] tid;
        string t;
        int k;
        int n;
        tid = {8'(b), 8'hc3};
        {fault_no_input, fault_memory, fault_system, fault_param, samples_lost, buf_not_full} = r[5:0];
        n = r[13:6] == 8'h00 ? 259 : 9;
        if (n == 259 && r[45:30] == 16'h0001) begin
            fill(b);
            snap_b = b;
            snap_acq = samples_lost ? 8'h02 : {7'h00, buf_not_full};
            snap_h = {2'b00, fault_param, 2'b00, fault_no_input, fault_memory, fault_system, 8'h00};
        end
        u_sdrf_host.request({tid, r[53:14]}, 1'b1, ok);
        if (!ok) begin
            fails++;
            complete_run();
        end
        {exp_b[0], exp_b[1], exp_b[2], exp_b[3], exp_b[4], exp_b[5], exp_b[6], exp_b[7], exp_b[8]} =
            {tid, 16'h0000, n == 9 ? 16'h0003 : 16'h00fd, 8'h01, 8'h47, n == 9 ? r[13:6] : snap_acq};
        k = 9;
        for (int s = 0; s < 4; s++) begin
            t = $sformatf("2024-05-1%0d12:34:5%0d.67%0d", s, snap_b % 10, s);
            for (int i = 0; i < 22; i++) exp_b[k + i] = t[i];
            k += 22;
            for (int c = 0; c < 8; c++) begin
                {exp_b[k + 4 * c], exp_b[k + 4 * c + 1], exp_b[k + 4 * c + 2], exp_b[k + 4 * c + 3]} =
                    {8'(snap_b), 8'(s), 8'(c), 8'ha5};
                exp_b[k + 32 + c] = {1'(s), 1'(c), 6'(c * 8 + s)};
            end
            k += 40;
        end
        {exp_b[257], exp_b[258]} = snap_h;
        check("frame length", 16'(u_sdrf_host.rx_n), 16'(n));
        for (int i = 0; i < n; i++) check($sformatf("byte %0d", i), {8'h00, u_sdrf_host.rx[i]}, {8'h00, exp_b[i]});
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        {samp_wr, stamp_wr, samp_set, stamp_set, samp_ch, samp_value, samp_err_code, samp_adj_err, samp_cj_err} = '0;
        {stamp_bcd, buf_not_full, samples_lost, fault_param, fault_system, fault_memory, fault_no_input} = '0;
        // Function, selection, length, failure code, then faults and acquisition inputs
        rows = '{{8'h47, 16'h0001, 16'h0004, 8'h00, 6'h00},
                 {8'h47, 16'h0002, 16'h0004, 8'h00, 6'h3f},
                 {8'h47, 16'h0001, 16'h0004, 8'h00, 6'h05},
                 {8'h47, 16'h0001, 16'h0004, 8'h00, 6'h0a},
                 {8'h47, 16'h0001, 16'h0004, 8'h00, 6'h13},
                 {8'h47, 16'h0001, 16'h0004, 8'h00, 6'h24},
                 {8'h46, 16'h0001, 16'h0004, 8'h01, 6'h00},
                 {8'h47, 16'h0003, 16'h0004, 8'h02, 6'h00},
                 {8'h47, 16'h0001, 16'h0005, 8'h03, 6'h00},
                 {8'h00, 16'h0000, 16'h0000, 8'h01, 6'h00},
                 {8'h47, 16'h0000, 16'h0006, 8'h02, 6'h00}};
        repeat (8) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        // Odd rows run with the sink stalling
        foreach (rows[i]) begin
            u_sdrf_host.stall = i[0];
            run_row(rows[i], i + 1);
        end
        // Reset in mid-frame drops the stream at once
        u_sdrf_host.request({16'h0bad, rows[0][53:14]}, 1'b0, ok);
        check("mid frame take", {15'h0000, ok}, 16'h0001);
        repeat (20) @(negedge clock);
        reset = 1'b1;
        @(negedge clock);
        check("valid in reset", {15'h0000, tx_valid}, 16'h0000);
        check("ready in reset", {15'h0000, req_ready}, 16'h0001);
        reset = 1'b0;
        u_sdrf_host.stall = 1'b1;
        run_row(rows[2], 12);
        complete_run();
    end
endmodule // sdrf_framer_tb

//--- sdrf_host.sv
// Host model: issues acquire-data requests and takes the reply stream
module sdrf_host (
    input wire clock,
    output logic req_valid,
    input wire req_ready,
    output logic [15:0] req_transaction_identifier,
    output logic [7:0] req_function_code,
    output logic [15:0] req_selection,
    output logic [15:0] req_length,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b0;
    logic [7:0] rx [0:258];
    int rx_n = 0;
    initial begin
        {req_valid, req_transaction_identifier, req_function_code, req_selection, req_length} = '0;
        tx_ready = 1'b1;
    end
    // A stalling sink drops ready every other cycle
    always @(negedge clock) tx_ready <= stall ? ~tx_ready : 1'b1;
    // Store each accepted byte; a cut frame cannot overrun the store
    always @(posedge clock) begin
        if (tx_valid && tx_ready && rx_n < 259) begin
            rx[rx_n] <= tx_data;
            rx_n <= rx_n + 1;
        end
    end
    // Hold the request until ready is seen, then wait out the reply if asked
    task automatic request(input logic [55:0] r, input bit full, output bit ok);
        int i;
        bit done;
        ok = 1'b0;
        @(negedge clock);
        rx_n = 0;
        req_valid = 1'b1;
        {req_transaction_identifier, req_function_code, req_selection, req_length} = r;
        for (i = 0; i < 50 && !ok; i++) begin
            @(posedge clock);
            ok = req_ready;
        end
        @(negedge clock);
        req_valid = 1'b0;
        {req_transaction_identifier, req_function_code, req_selection, req_length} = ~r;
        done = !full || !ok;
        for (i = 0; i < 2000 && !done; i++) begin
            @(posedge clock);
            done = tx_valid && tx_ready && tx_last;
        end
        ok = ok && done;
        if (full) @(negedge clock);
    endtask
endmodule // sdrf_host

//--- sdrf_map.vh
// Constants of the acquire-data reply framer: codes, field layouts, frame positions
`ifndef SDRF_MAP_VH
`define SDRF_MAP_VH

// Header and command codes
`define SDRF_PROTO_ID 16'h0000
`define SDRF_STATION_ID 8'h01
`define SDRF_FC_ACQUIRE 8'h47
`define SDRF_LEN_OK 16'h00fd
`define SDRF_LEN_ERR 16'h0003
`define SDRF_REQ_LEN 16'h0004
`define SDRF_SEL_LATEST 16'h0001
`define SDRF_SEL_RESEND 16'h0002

// Failure codes of the short reply
`define SDRF_FAIL_NONE 8'h00
`define SDRF_FAIL_FUNC 8'h01
`define SDRF_FAIL_REG 8'h02
`define SDRF_FAIL_COUNT 8'h03

// Acquisition status codes
`define SDRF_ACQ_OK 8'h00
`define SDRF_ACQ_NOT_FULL 8'h01
`define SDRF_ACQ_LOST 8'h02

// Unit health codes
`define SDRF_HLTH_OK 16'h0000
`define SDRF_HLTH_PARAM 16'h2000
`define SDRF_HLTH_SYSTEM 16'h0100
`define SDRF_HLTH_MEMORY 16'h0200
`define SDRF_HLTH_NO_INPUT 16'h0400

// Channel status byte: error code bits 5..0, adjustment flag bit 6, cold junction flag bit 7
`define SDRF_STS_CODE_W 6

// Stamp word: BCD digits year(16) month(8) day(8) hour(8) min(8) sec(8) ms(12)
`define SDRF_STAMP_W 68
`define SDRF_YEAR_LSB 52
`define SDRF_MON_LSB 44
`define SDRF_DAY_LSB 36
`define SDRF_HOUR_LSB 28
`define SDRF_MIN_LSB 20
`define SDRF_SEC_LSB 12
`define SDRF_MS_LSB 0

// Text separators and digit base
`define SDRF_CH_ZERO 8'h30
`define SDRF_CH_DASH 8'h2d
`define SDRF_CH_COLON 8'h3a
`define SDRF_CH_DOT 8'h2e

// Byte positions inside the header, a sample set and the health word
`define SDRF_HDR_LAST 6'h08
`define SDRF_VAL_START 6'h16
`define SDRF_STS_START 6'h36
`define SDRF_SET_LAST 6'h3d
`define SDRF_LAST_SET 2'h3
`define SDRF_HLTH_LAST 6'h01

// Framer states
`define SDRF_ST_IDLE 2'h0
`define SDRF_ST_HDR 2'h1
`define SDRF_ST_SET 2'h2
`define SDRF_ST_HLTH 2'h3

`endif

//--- sdrf_stamp_text.v
// Converts one character position of a BCD time stamp into its ASCII text
`include "sdrf_map.vh"

module sdrf_stamp_text (
    input wire [`SDRF_STAMP_W-1:0] stamp,
    input wire [4:0] char_idx,
    output reg [7:0] char_out
);

    reg [3:0] digit;
    reg is_sep;
    reg [7:0] sep_char;

    // Date chars 0..9 then time chars 10..21, digits most significant first
    always @* begin
        digit = 4'h0;
        is_sep = 1'b0;
        sep_char = `SDRF_CH_DASH;
        case (char_idx)
            5'h00: digit = stamp[`SDRF_YEAR_LSB+12 +: 4];
            5'h01: digit = stamp[`SDRF_YEAR_LSB+8 +: 4];
            5'h02: digit = stamp[`SDRF_YEAR_LSB+4 +: 4];
            5'h03: digit = stamp[`SDRF_YEAR_LSB +: 4];
            5'h04: is_sep = 1'b1;
            5'h05: digit = stamp[`SDRF_MON_LSB+4 +: 4];
            5'h06: digit = stamp[`SDRF_MON_LSB +: 4];
            5'h07: is_sep = 1'b1;
            5'h08: digit = stamp[`SDRF_DAY_LSB+4 +: 4];
            5'h09: digit = stamp[`SDRF_DAY_LSB +: 4];
            5'h0a: digit = stamp[`SDRF_HOUR_LSB+4 +: 4];
            5'h0b: digit = stamp[`SDRF_HOUR_LSB +: 4];
            5'h0c: begin
                is_sep = 1'b1;
                sep_char = `SDRF_CH_COLON;
            end
            5'h0d: digit = stamp[`SDRF_MIN_LSB+4 +: 4];
            5'h0e: digit = stamp[`SDRF_MIN_LSB +: 4];
            5'h0f: begin
                is_sep = 1'b1;
                sep_char = `SDRF_CH_COLON;
            end
            5'h10: digit = stamp[`SDRF_SEC_LSB+4 +: 4];
            5'h11: digit = stamp[`SDRF_SEC_LSB +: 4];
            5'h12: begin
                is_sep = 1'b1;
                sep_char = `SDRF_CH_DOT;
            end
            5'h13: digit = stamp[`SDRF_MS_LSB+8 +: 4];
            5'h14: digit = stamp[`SDRF_MS_LSB+4 +: 4];
            5'h15: digit = stamp[`SDRF_MS_LSB +: 4];
            default: digit = 4'h0;
        endcase
        // BCD digit becomes its ASCII figure by offset from '0'
        char_out = is_sep ? sep_char : (`SDRF_CH_ZERO | {4'h0, digit});
    end

endmodule // sdrf_stamp_text
